// ==== hdl/mps_seq.sv ====
`timescale 1ns/1ps
`include "mps_consts.svh"
module mps_seq #(
	parameter int N_PINS     = 8,
	parameter int SETTLE_CYC = `MPS_XO_SETTLE_CYC
) (
	input  wire logic              i_core_clk,      // Core clock, 50 MHz.
	input  wire logic              i_nrst,          // Async reset, low.
	input  wire logic              i_io_supply,     // I/O supply good pin.
	input  wire logic              i_power_enable,  // Power enable pin.
	input  wire logic              i_hard_reset_n,  // Hard reset pin, low.
	input  wire logic              i_sleep_clk,     // 32.768 kHz sleep clock.
	input  wire logic              i_fw_done,       // Firmware configured.
	input  wire logic [N_PINS-1:0] i_fw_oe,         // Programmed drivers.
	input  wire logic [N_PINS-1:0] i_fw_pull,       // Programmed pulls.
	output logic [N_PINS-1:0]      o_pin_oe,        // Output driver enables.
	output logic [N_PINS-1:0]      o_pin_ie,        // Input buffer enables.
	output logic [N_PINS-1:0]      o_pin_pull_en,   // Pull resistor enables.
	output logic                   o_core_rst_n,    // Core reset, low.
	output logic                   o_init_start,    // Init start pulse.
	output mps_pkg::mps_state_t    o_state,         // Present pin state.
	output logic                   o_sleep_tick,    // Sleep clock rising edge pulse.
	output logic                   o_sleep_clk_ok,  // Sleep clock in range.
	output logic                   o_settle_err     // Reset rose too early.
);
	import mps_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [3:0] sync1_q, sync1_d;
	logic [3:0] sync2_q, sync2_d;
	logic       slp_prev_q, slp_prev_d;
	logic       io_s, en_s, rstn_s, slp_s;

	// Two stages for each pin; only the second stage is read.
	// The supply, enable and reset pins follow the host's own timing,
	// so a first stage may go metastable; nothing but the second stage
	// may look at it. The sleep clock takes the same path.
	always_comb begin
		sync1_d = {i_sleep_clk, i_hard_reset_n, i_power_enable, i_io_supply};
		sync2_d = sync1_q;
		slp_prev_d = slp_s;
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
			slp_prev_q <= 1'b0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			slp_prev_q <= slp_prev_d;
		end
	end

	// Named views of the second synchroniser stage.
	assign io_s   = sync2_q[0];
	assign en_s   = sync2_q[1];
	assign rstn_s = sync2_q[2];
	assign slp_s  = sync2_q[3];

	// ****************************************
	// Power state machine
	// ****************************************
	mps_state_t state_q, state_d;
	logic       rstn_prev_q, rstn_prev_d;
	logic       init_q, init_d;
	logic [31:0] settle_q, settle_d;
	logic       err_q, err_d;

	// Tracks the pin state; supply or enable low forces power-down, hard reset low forces power-on reset.
	// The settle counter runs only while the crystal is powered and
	// hard reset is held, and it saturates, so a long hold is harmless.
	// An early release is not refused: the core still starts, and the
	// sticky error flag tells the host that its timing was short.
	always_comb begin
		state_d = state_q;
		rstn_prev_d = rstn_s;
		init_d = 1'b0;
		settle_d = settle_q;
		err_d = err_q;
		if (!io_s || !en_s) begin
			state_d = MPS_OFF;
			settle_d = 32'h0;
		end else if (!rstn_s) begin
			state_d = MPS_POR;
			if (settle_q < 32'(SETTLE_CYC))
				settle_d = settle_q + 32'h1;
		end else begin
			unique case (state_q)
				MPS_OFF, MPS_POR: begin
					// Start init only on the rising edge of hard reset.
					// A reset pin already high at power-up does not count.
					if (!rstn_prev_q) begin
						state_d = MPS_DEFAULT;
						init_d = 1'b1;
						// Flag a release before the crystal settled.
						if (settle_q < 32'(SETTLE_CYC))
							err_d = 1'b1;
					end
				end
				MPS_DEFAULT: begin
					if (i_fw_done)
						state_d = MPS_PROGRAMMED;
				end
				// Only a drop of supply, enable or hard reset leaves here.
				MPS_PROGRAMMED: state_d = MPS_PROGRAMMED;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= MPS_OFF;
			rstn_prev_q <= 1'b0;
			init_q <= 1'b0;
			settle_q <= 32'h0;
			err_q <= 1'b0;
		end else begin
			state_q <= state_d;
			rstn_prev_q <= rstn_prev_d;
			init_q <= init_d;
			settle_q <= settle_d;
			err_q <= err_d;
		end
	end

	// ****************************************
	// Pin control
	// ****************************************
	logic [N_PINS-1:0] oe_q, oe_d, ie_q, ie_d, pu_q, pu_d;

	// Drivers, buffers and pulls chosen from the power state.
	// They are worked out from the next state, so that the pin enables
	// and the state register change on the same edge and no pin ever
	// shows the settings of a state that has already ended.
	always_comb begin
		oe_d = '0;
		ie_d = '0;
		pu_d = '0;
		unique case (state_d)
			MPS_OFF: begin
				// Core supply is off: every pin stays floating.
			end
			MPS_POR: pu_d = '1;
			MPS_DEFAULT: begin
				ie_d = '1;
				pu_d = '1;
			end
			MPS_PROGRAMMED: begin
				oe_d = i_fw_oe;
				ie_d = ~i_fw_oe;
				pu_d = i_fw_pull;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			oe_q <= '0;
			ie_q <= '0;
			pu_q <= '0;
		end else begin
			oe_q <= oe_d;
			ie_q <= ie_d;
			pu_q <= pu_d;
		end
	end

	// ****************************************
	// Sleep clock monitor
	// ****************************************
	logic [9:0] half_q, half_d;
	logic       ok_q, ok_d, tick_q, tick_d;

	// Measures each sleep clock half period against its tolerance window.
	// The synchroniser adds up to one core cycle of jitter to each
	// measured half period, so the window is a little wider than the
	// crystal tolerance alone. A clock that stops saturates the counter
	// and drops the good flag.
	always_comb begin
		half_d = half_q;
		ok_d = ok_q;
		tick_d = 1'b0;
		if (slp_s != slp_prev_q) begin
			tick_d = slp_s;
			// The counter misses the cycle of the edge itself, so one
			// cycle is added before the window is applied.
			ok_d = ((half_q + 10'h001) >= `MPS_SLP_HALF_MIN) &&
				((half_q + 10'h001) <= `MPS_SLP_HALF_MAX);
			half_d = `MPS_SLP_CNT_RST;
		end else if (half_q != 10'h3FF) begin
			half_d = half_q + 10'h001;
		end else begin
			ok_d = 1'b0;                              // Clock has stopped.
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			half_q <= `MPS_SLP_CNT_RST;
			ok_q <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			half_q <= half_d;
			ok_q <= ok_d;
			tick_q <= tick_d;
		end
	end

	// Outputs come straight from registers; the core reset is a decode
	// of the state register alone, never of the raw pins.
	assign o_pin_oe       = oe_q;
	assign o_pin_ie       = ie_q;
	assign o_pin_pull_en  = pu_q;
	assign o_core_rst_n   = (state_q == MPS_DEFAULT) ||
		(state_q == MPS_PROGRAMMED);
	assign o_init_start   = init_q;
	assign o_state        = state_q;
	assign o_sleep_tick   = tick_q;
	assign o_sleep_clk_ok = ok_q;
	assign o_settle_err   = err_q;
endmodule

// ==== hdl/mps_consts.svh ====
`ifndef MPS_CONSTS_SVH
`define MPS_CONSTS_SVH
// Overview of operation
// - With the core off, outputs, inputs and pulls are all disabled.
// - In power-on reset, outputs and inputs are off and pulls are on.
// - Out of reset but unprogrammed, outputs off, inputs and pulls on.
// - A 32.768 kHz sleep clock within 500 ppm is supplied and monitored.

// Crystal settle time in microseconds and its count of core cycles.
`define MPS_XO_SETTLE_US     5000
`define MPS_CLK_MHZ          50
`define MPS_XO_SETTLE_CYC    (`MPS_XO_SETTLE_US * `MPS_CLK_MHZ)
// Sleep clock nominal frequency in Hz and tolerance in ppm.
`define MPS_SLP_HZ           32768
`define MPS_SLP_PPM          500
// Core cycles per sleep clock half period, nominal 762.9, with tolerance.
`define MPS_SLP_HALF_MIN     10'h2FA
`define MPS_SLP_HALF_MAX     10'h2FF
`define MPS_SLP_CNT_RST      10'h000
`endif

// ==== hdl/mps_pkg.sv ====
package mps_pkg;
	// Device power and pin states.
	typedef enum logic [1:0] {
		MPS_OFF,
		MPS_POR,
		MPS_DEFAULT,
		MPS_PROGRAMMED
	} mps_state_t;
endpackage

// ==== testbench/mps_seq_monitor.sv ====
`timescale 1ns/1ps
module mps_seq_monitor #(parameter int N_PINS = 8) (
	input logic                i_core_clk,    // Clock.
	input logic                i_nrst,        // Reset.
	input logic                i_io_supply,   // Supply.
	input logic [N_PINS-1:0]   i_fw_oe,       // Set drivers.
	input logic [N_PINS-1:0]   o_pin_oe,      // Drivers.
	input logic [N_PINS-1:0]   o_pin_ie,      // Inputs.
	input logic [N_PINS-1:0]   o_pin_pull_en, // Pulls.
	input logic                o_core_rst_n,  // Core reset.
	input mps_pkg::mps_state_t o_state        // State.
);
	import mps_pkg::*;
	// Pin enables follow the state; the state follows the pins.
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	sequence s_off_soon;
		##[1:4] o_state == MPS_OFF;
	endsequence
	off_pins_a: assert property (o_state == MPS_OFF |->
		{o_pin_oe, o_pin_ie, o_pin_pull_en} == '0) else $error("Pins on.");
	por_pins_a: assert property (o_state == MPS_POR |->
		{o_pin_oe, o_pin_ie} == '0 && &o_pin_pull_en) else $error("Bad POR.");
	dflt_pins_a: assert property (o_state == MPS_DEFAULT |->
		o_pin_oe == '0 && &o_pin_ie && &o_pin_pull_en) else $error("Bad idle.");
	prog_inv_a: assert property (o_state == MPS_PROGRAMMED |->
		o_pin_ie == ~o_pin_oe) else $error("Input not inverse.");
	prog_follow_a: assert property (o_state == MPS_PROGRAMMED &&
		$past(o_state) == o_state |-> o_pin_oe == $past(i_fw_oe))
		else $error("Drivers stale.");
	off_follow_a: assert property (!i_io_supply |-> s_off_soon)
		else $error("On without supply.");
	core_hold_a: assert property (o_state inside {MPS_OFF, MPS_POR}
		|-> !o_core_rst_n) else $error("Core out of reset.");
	core_rise_a: assert property ($rose(o_core_rst_n) |->
		$past(o_state) == MPS_POR) else $error("Core left reset early.");
endmodule
bind mps_seq mps_seq_monitor #(.N_PINS(N_PINS)) u_mon (.i_core_clk, .i_nrst,
	.i_io_supply, .i_fw_oe, .o_pin_oe, .o_pin_ie, .o_pin_pull_en,
	.o_core_rst_n, .o_state);

// ==== testbench/mps_host.sv ====
`timescale 1ns/1ps
module mps_host (
	input  logic i_core_clk,     // Clock.
	output logic o_io_supply,    // Supply.
	output logic o_power_enable, // Enable.
	output logic o_hard_reset_n, // Hard reset.
	output logic o_sleep_clk     // Sleep clock.
);
	// Pins start driven low, the sleep clock included.
	initial begin
		o_io_supply = 1'h0;
		o_power_enable = 1'h0;
		o_hard_reset_n = 1'h0;
		o_sleep_clk = 1'h0;
	end
	// Free running clock close to 32.768 kHz.
	always #15259 o_sleep_clk = ~o_sleep_clk;
	// One pin step just after an edge; callers keep the order.
	task automatic drive(input logic [2:0] v);
		@(posedge i_core_clk);
		#1 {o_io_supply, o_power_enable, o_hard_reset_n} = v;
	endtask
endmodule

// ==== testbench/module_power_sequencing_tb_top.sv ====
`timescale 1ns/1ps
module module_power_sequencing_tb_top;
	import mps_pkg::*;
	logic        clk, nrst, fw_done, io, en, rn, slp, crst_n, ok, serr;
	logic        init, tick;
	logic [7:0]  fw_oe, fw_pull, oe, ie, pl;
	logic [31:0] seed;
	mps_state_t  st;
	int          num_errors, compares;
	int          inits, ticks, slp_rises;
	mps_host host (.i_core_clk(clk), .o_io_supply(io),
		.o_power_enable(en), .o_hard_reset_n(rn), .o_sleep_clk(slp));
	mps_seq #(.N_PINS(8), .SETTLE_CYC(20)) dut (.i_core_clk(clk),
		.i_nrst(nrst), .i_io_supply(io), .i_power_enable(en),
		.i_hard_reset_n(rn), .i_sleep_clk(slp), .i_fw_done(fw_done),
		.i_fw_oe(fw_oe), .i_fw_pull(fw_pull), .o_pin_oe(oe), .o_pin_ie(ie),
		.o_pin_pull_en(pl), .o_core_rst_n(crst_n), .o_init_start(init),
		.o_state(st), .o_sleep_tick(tick), .o_sleep_clk_ok(ok),
		.o_settle_err(serr));
	// Random stream and the pin enables each state should show.
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	function automatic logic [23:0] want(input mps_state_t s);
		case (s)
			MPS_OFF: return 24'h000000;
			MPS_POR: return 24'h0000FF;
			MPS_DEFAULT: return 24'h00FFFF;
			default: return {fw_oe, ~fw_oe, fw_pull};
		endcase
	endfunction
	// Comparison, state step and verdict.
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n, input mps_state_t s);
		repeat (n) @(posedge clk);
		#1 check(24'(st), 24'(s));
		check({oe, ie, pl}, want(s));
	endtask
	task automatic conclude(input bit hang);
		num_errors += hang;
		$display("%0d checks, %0d errors", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial forever #10 clk = ~clk;
	initial #200000 conclude(1'h1);
	// Pulse counts, taken at the falling edge, away from the launch.
	always @(negedge clk) begin
		inits += int'(init);
		ticks += int'(tick);
	end
	// Rising edges of the sleep clock that the host sends.
	always @(posedge slp)
		slp_rises++;
	// Power up, program, power down, then release reset too soon.
	initial begin
		clk = 1'h0;
		nrst = 1'h0;
		fw_done = 1'h0;
		fw_oe = 8'h00;
		fw_pull = 8'h00;
		seed = 32'hE9BF;
		repeat (6) @(posedge clk);
		#1 nrst = 1'h1;
		step(3, MPS_OFF);
		host.drive(3'h4);
		host.drive(3'h6);
		step(25, MPS_POR);
		host.drive(3'h7);
		step(4, MPS_DEFAULT);
		check(24'({crst_n, serr}), 24'h2);
		check(24'(inits), 24'h1);
		fw_done = 1'h1;
		for (int k = 0; k < 12; k++) begin
			seed = xs(seed);
			fw_oe = k == 1 ? 8'hFF : seed[7:0] & {8{k != 0}};
			fw_pull = seed[15:8];
			step(2, MPS_PROGRAMMED);
		end
		step(2400, MPS_PROGRAMMED);
		check(24'(ok), 24'h1);
		check(24'(ticks), 24'(slp_rises));
		fw_done = 1'h0;
		host.drive(3'h4);
		host.drive(3'h0);
		step(4, MPS_OFF);
		host.drive(3'h6);
		step(5, MPS_POR);
		host.drive(3'h7);
		step(4, MPS_DEFAULT);
		check(24'(serr), 24'h1);
		check(24'(inits), 24'h2);
		conclude(1'h0);
	end
endmodule
